// ### logic/mii3_pkg.sv
// constants shared by the port-3 nibble interface and its helpers
// assumes a 25 MHz link reference clock and a 25 MHz system clock
package mii3_pkg;

  // ---------------------------------------------------------------
  // nibble clock rates
  // ---------------------------------------------------------------
  localparam int LINK_HZ      = 25_000_000;
  localparam int NIB_HZ_10M   = 2_500_000;
  localparam int NIB_HZ_100M  = 25_000_000;
  localparam int NIB_DIV_10M  = LINK_HZ / NIB_HZ_10M;
  localparam int NIB_DIV_100M = LINK_HZ / NIB_HZ_100M;

  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST_10M  = DIV_W'(NIB_DIV_10M - 1);
  localparam logic [DIV_W-1:0] DIV_LAST_100M = DIV_W'(NIB_DIV_100M - 1);
  localparam logic [DIV_W-1:0] DIV_HALF_10M  = DIV_W'(NIB_DIV_10M / 2);
  localparam logic [DIV_W-1:0] DIV_ZERO      = 4'h0;
  localparam logic [DIV_W-1:0] DIV_ONE       = 4'h1;

  // ---------------------------------------------------------------
  // data path and strap
  // ---------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam logic [NIB_W-1:0] NIB_IDLE = 4'h0;

  // strap level on the receive-valid pin that selects PHY mode
  localparam logic       STRAP_PHY_LEVEL = 1'b1;
  // edges after reset release before the synchronised strap is valid
  localparam logic [1:0] STRAP_SETTLE    = 2'h2;
  localparam logic [1:0] STRAP_ZERO      = 2'h0;
  localparam logic [1:0] STRAP_ONE       = 2'h1;

endpackage

// ### logic/level_sync.sv
// two-stage synchroniser for level signals
// assumes each bit is a level that is stable for several clock edges
`timescale 1ns/1ps

module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  // first stage, read only by the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      meta_ff <= '0;
    else
      meta_ff <= d;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_ff <= '0;
    else
      hold_ff <= meta_ff;
  end

  assign q = hold_ff;

endmodule // level_sync

// ### logic/port3_mii_if.sv
// port-3 nibble interface in PHY or MAC mode, with bypass control
// assumes the switch core sits on MCLK for control and on LINK_CLK
// for the nibble streams; pins are sampled through two flip-flops
`timescale 1ns/1ps

module port3_mii_if
  import mii3_pkg::*;
(
  input  wire logic             MCLK,
  input  wire logic             RESETN,
  input  wire logic             LINK_CLK,
  input  wire logic             SPEED_100,
  input  wire logic             FULL_DUPLEX,
  output logic                  MODE_PHY,
  output logic                  MODE_VALID,
  output logic                  BYPASS_ACTIVE,
  output logic                  QUEUE_FLUSH,
  input  wire logic             TX_EN_PIN,
  input  wire logic [NIB_W-1:0] TXD_PIN,
  input  wire logic             PORT3_BYPASS_INPUT,
  input  wire logic             RX_DV_PIN_I,
  output logic                  RX_DV_PIN_O,
  output logic                  RX_DV_PIN_OE_N,
  output logic      [NIB_W-1:0] RXD_PIN,
  output logic                  TX_CLK_PIN,
  output logic                  RX_CLK_PIN,
  output logic                  CRS_PIN,
  output logic                  COL_PIN,
  input  wire logic             EG_VALID,
  input  wire logic [NIB_W-1:0] EG_DATA,
  output logic                  EG_READY,
  output logic                  IG_VALID,
  output logic      [NIB_W-1:0] IG_DATA,
  output logic                  IG_EOF,
  output logic                  IG_DROP
);

  // ---------------------------------------------------------------
  // system clock domain: strap and bypass
  // ---------------------------------------------------------------
  logic       strap_s;
  logic       bp_s;
  logic [1:0] strap_cnt_ff;
  logic       strap_done_ff;
  logic       mode_phy_ff;
  logic       bypass_ff;
  logic       nxt_bypass;
  logic       flush_ff;

  level_sync #(.WIDTH(2)) u_msync (
    .clk   (MCLK),
    .rst_n (RESETN),
    .d     ({RX_DV_PIN_I, PORT3_BYPASS_INPUT}),
    .q     ({strap_s, bp_s})
  );

  // waits out the synchroniser after release
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      strap_cnt_ff <= STRAP_ZERO;
    else if (strap_cnt_ff != STRAP_SETTLE)
      strap_cnt_ff <= strap_cnt_ff + STRAP_ONE;
  end

  // mode caught once, then frozen
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      strap_done_ff <= 1'b0;
      mode_phy_ff   <= 1'b0;
    end
    else if (!strap_done_ff && strap_cnt_ff == STRAP_SETTLE)
    begin
      strap_done_ff <= 1'b1;
      mode_phy_ff   <= (strap_s == STRAP_PHY_LEVEL);
    end
  end

  // bypass pin only counts in PHY mode; in MAC mode it is rx error
  assign nxt_bypass = strap_done_ff & mode_phy_ff & bp_s;

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      bypass_ff <= 1'b0;
    else
      bypass_ff <= nxt_bypass;
  end

  // one pulse to the queue manager on entry
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      flush_ff <= 1'b0;
    else
      flush_ff <= nxt_bypass & ~bypass_ff;
  end

  assign MODE_PHY       = mode_phy_ff;
  assign MODE_VALID     = strap_done_ff;
  assign BYPASS_ACTIVE  = bypass_ff;
  assign QUEUE_FLUSH    = flush_ff;
  // strap pin released until the mode is caught
  assign RX_DV_PIN_OE_N = ~strap_done_ff;

  // ---------------------------------------------------------------
  // link clock domain: reset and control crossing
  // ---------------------------------------------------------------
  logic             lrst_n;
  logic             en_l;
  logic             phy_l;
  logic             shut_l;
  logic             spd_l;
  logic             fdx_l;
  logic             active;
  logic             rxer_s;
  logic             txen_s;
  logic [NIB_W-1:0] txd_s;

  // async assert, synchronous release
  level_sync #(.WIDTH(1)) u_lrst (
    .clk   (LINK_CLK),
    .rst_n (RESETN),
    .d     (1'b1),
    .q     (lrst_n)
  );

  level_sync #(.WIDTH(5)) u_lctl (
    .clk   (LINK_CLK),
    .rst_n (lrst_n),
    .d     ({strap_done_ff, mode_phy_ff, bypass_ff,
             SPEED_100, FULL_DUPLEX}),
    .q     ({en_l, phy_l, shut_l, spd_l, fdx_l})
  );

  // same nibble pins in both modes, only their names change
  level_sync #(.WIDTH(NIB_W + 2)) u_lpin (
    .clk   (LINK_CLK),
    .rst_n (lrst_n),
    .d     ({PORT3_BYPASS_INPUT, TX_EN_PIN, TXD_PIN}),
    .q     ({rxer_s, txen_s, txd_s})
  );

  assign active = en_l & ~shut_l;

  // ---------------------------------------------------------------
  // nibble clock generation
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] div_last;
  logic [DIV_W-1:0] nxt_div;
  logic             nib_stb;
  logic             nib_clk_ff;

  assign div_last = spd_l ? DIV_LAST_100M : DIV_LAST_10M;
  assign nib_stb  = (div_ff >= div_last);
  assign nxt_div  = nib_stb ? DIV_ZERO : div_ff + DIV_ONE;

  always_ff @(posedge LINK_CLK or negedge lrst_n)
  begin
    if (!lrst_n)
      div_ff <= DIV_ZERO;
    else
      div_ff <= nxt_div;
  end

  // high for the first half of each 10 Mb/s nibble period
  always_ff @(posedge LINK_CLK or negedge lrst_n)
  begin
    if (!lrst_n)
      nib_clk_ff <= 1'b0;
    else
      nib_clk_ff <= (nxt_div < DIV_HALF_10M);
  end

  // at 100 Mb/s the reference itself is the nibble clock
  assign TX_CLK_PIN = spd_l ? LINK_CLK : nib_clk_ff;
  assign RX_CLK_PIN = spd_l ? LINK_CLK : nib_clk_ff;

  // ---------------------------------------------------------------
  // egress: switch to the receive-side pins
  // ---------------------------------------------------------------
  logic             dv_ff;
  logic [NIB_W-1:0] rxd_ff;

  // drains and discards egress while shut down
  assign EG_READY = (active & nib_stb) | shut_l;

  // no error line is driven toward the far side
  always_ff @(posedge LINK_CLK or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      dv_ff  <= 1'b0;
      rxd_ff <= NIB_IDLE;
    end
    else if (!active)
    begin
      dv_ff  <= 1'b0;
      rxd_ff <= NIB_IDLE;
    end
    else if (nib_stb)
    begin
      dv_ff  <= EG_VALID;
      rxd_ff <= EG_VALID ? EG_DATA : NIB_IDLE;
    end
  end

  assign RX_DV_PIN_O = dv_ff;
  assign RXD_PIN     = rxd_ff;

  // ---------------------------------------------------------------
  // ingress: transmit-side pins to the switch
  // ---------------------------------------------------------------
  logic             in_active_ff;
  logic             err_ff;
  logic             ig_valid_ff;
  logic [NIB_W-1:0] ig_data_ff;
  logic             ig_eof_ff;
  logic             ig_drop_ff;
  logic             frame_end;

  assign frame_end = nib_stb & in_active_ff & ~txen_s;

  always_ff @(posedge LINK_CLK or negedge lrst_n)
  begin
    if (!lrst_n)
      in_active_ff <= 1'b0;
    else if (!active)
      in_active_ff <= 1'b0;
    else if (nib_stb)
      in_active_ff <= txen_s;
  end

  // error seen anywhere in the frame marks it for dropping
  always_ff @(posedge LINK_CLK or negedge lrst_n)
  begin
    if (!lrst_n)
      err_ff <= 1'b0;
    else if (!active || (nib_stb && !txen_s))
      err_ff <= 1'b0;
    else if (nib_stb && !phy_l && rxer_s)
      err_ff <= 1'b1;
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      ig_valid_ff <= 1'b0;
      ig_data_ff  <= NIB_IDLE;
    end
    else
    begin
      ig_valid_ff <= active & nib_stb & txen_s;
      if (active && nib_stb && txen_s)
        ig_data_ff <= txd_s;
    end
  end

  // frame cut by shutdown ends as a dropped frame
  always_ff @(posedge LINK_CLK or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      ig_eof_ff  <= 1'b0;
      ig_drop_ff <= 1'b0;
    end
    else if (!active)
    begin
      ig_eof_ff  <= in_active_ff;
      ig_drop_ff <= in_active_ff;
    end
    else
    begin
      ig_eof_ff  <= frame_end;
      ig_drop_ff <= frame_end & err_ff;
    end
  end

  assign IG_VALID = ig_valid_ff;
  assign IG_DATA  = ig_data_ff;
  assign IG_EOF   = ig_eof_ff;
  assign IG_DROP  = ig_drop_ff;

  // ---------------------------------------------------------------
  // carrier sense and collision
  // ---------------------------------------------------------------
  logic crs_ff;
  logic col_ff;

  always_ff @(posedge LINK_CLK or negedge lrst_n)
  begin
    if (!lrst_n)
      crs_ff <= 1'b0;
    else
      crs_ff <= active & (in_active_ff | dv_ff);
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n)
  begin
    if (!lrst_n)
      col_ff <= 1'b0;
    else
      col_ff <= active & ~fdx_l & dv_ff & in_active_ff;
  end

  assign CRS_PIN = crs_ff;
  assign COL_PIN = col_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_strap_capture: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (!strap_done_ff && strap_cnt_ff == STRAP_SETTLE) |=>
      (strap_done_ff && mode_phy_ff == $past(strap_s))
  ) else $error("mode not taken from strap");

  a_mode_frozen: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    strap_done_ff |=> (strap_done_ff && $stable(mode_phy_ff))
  ) else $error("latched mode changed");

  a_strap_pin_free: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (strap_cnt_ff != STRAP_SETTLE) |-> RX_DV_PIN_OE_N
  ) else $error("strap pin driven before capture");

  a_bypass_entry: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (strap_done_ff && mode_phy_ff && bp_s) |=> BYPASS_ACTIVE
  ) else $error("bypass not entered");

  a_bypass_mac_mode: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (strap_done_ff && !mode_phy_ff) |-> !BYPASS_ACTIVE
  ) else $error("bypass taken in MAC mode");

  a_flush_once: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    $rose(bypass_ff) |-> (QUEUE_FLUSH ##1 !QUEUE_FLUSH)
  ) else $error("flush pulse wrong");

  a_shut_quiet: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    shut_l |=> (!RX_DV_PIN_O && !CRS_PIN && !COL_PIN)
  ) else $error("port active in bypass");

  // a speed change mid-period restarts the clock shape
  a_clk_half_10m: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n || spd_l)
    (!spd_l && nib_stb) |=> nib_clk_ff [*5] ##1 !nib_clk_ff
  ) else $error("10M nibble clock shape wrong");

  a_nibble_hold: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    (active && !nib_stb) |=> ($stable(RXD_PIN) && $stable(RX_DV_PIN_O))
  ) else $error("nibble changed between strobes");

  a_col_cause: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    COL_PIN |-> ($past(dv_ff) && $past(in_active_ff) && $past(!fdx_l))
  ) else $error("collision without overlap");

  a_err_drop: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    (active && frame_end && err_ff) |=> (IG_EOF && IG_DROP)
  ) else $error("errored frame not dropped");

  c_bypass: cover property (
    @(posedge MCLK) disable iff (!RESETN) $rose(bypass_ff));
  c_mac_mode: cover property (
    @(posedge MCLK) disable iff (!RESETN)
    $rose(strap_done_ff) && !mode_phy_ff);
  c_collision: cover property (
    @(posedge LINK_CLK) disable iff (!lrst_n) $rose(COL_PIN));
  c_drop: cover property (
    @(posedge LINK_CLK) disable iff (!lrst_n) IG_EOF && IG_DROP);

endmodule // port3_mii_if

// ### verification/mii3_far_end.sv
// far-end model: external MAC or PHY on the nibble pins
// assumes the device sources both nibble clocks
`timescale 1ns/1ps

module mii3_far_end (
  input  wire logic       tx_clk,
  input  wire logic       rx_clk,
  input  wire logic       dv_in,
  input  wire logic [3:0] d_in,
  output logic            en_out,
  output logic      [3:0] d_out
);
  logic [3:0] got_q[$];

  // no error output here, so only enable and data are tied low
  initial
  begin
    en_out = 1'b0;
    d_out  = 4'h0;
  end

  // sample away from the launching edge
  always @(negedge rx_clk)
    if (dv_in === 1'b1)
      got_q.push_back(d_in);

  task automatic send(input logic [3:0] nib[$]);
    foreach (nib[i])
    begin
      @(negedge tx_clk);
      en_out <= 1'b1;
      d_out  <= nib[i];
    end
    @(negedge tx_clk);
    en_out <= 1'b0;
    // released data must not keep the last nibble
    d_out  <= ~nib[nib.size()-1];
  endtask
endmodule // mii3_far_end

// ### verification/tb_top.sv
// bench for the port-3 nibble interface with a far-end model
// assumes MCLK 40 ns and an unrelated 30 ns link clock
`timescale 1ns/1ps

module tb_top;
  import mii3_pkg::*;

  logic       mclk, resetn, link_clk, speed_100, full_duplex;
  logic       mode_phy, mode_valid, bypass_active, queue_flush;
  logic       tx_en, bp_pin, strap, rx_dv_o, rx_dv_oe_n, rx_dv_line;
  logic [3:0] txd, rxd, eg_data, ig_data;
  logic       tx_clk, rx_clk, crs, col, eg_valid, eg_ready;
  logic       ig_valid, ig_eof, ig_drop, crs_seen, col_seen;
  int         n_mismatch, checks, n_eof, n_drop;
  logic [3:0] ig_q[$];
  logic [3:0] pat[$] = '{4'h5, 4'ha, 4'h0, 4'hf, 4'h3, 4'hc};

  // strap resistor sets the level until the device drives
  assign rx_dv_line = rx_dv_oe_n ? strap : rx_dv_o;

  port3_mii_if u_port3_mii_if (
    .MCLK(mclk), .RESETN(resetn), .LINK_CLK(link_clk),
    .SPEED_100(speed_100), .FULL_DUPLEX(full_duplex),
    .MODE_PHY(mode_phy), .MODE_VALID(mode_valid),
    .BYPASS_ACTIVE(bypass_active), .QUEUE_FLUSH(queue_flush),
    .TX_EN_PIN(tx_en), .TXD_PIN(txd), .PORT3_BYPASS_INPUT(bp_pin),
    .RX_DV_PIN_I(rx_dv_line), .RX_DV_PIN_O(rx_dv_o),
    .RX_DV_PIN_OE_N(rx_dv_oe_n), .RXD_PIN(rxd),
    .TX_CLK_PIN(tx_clk), .RX_CLK_PIN(rx_clk), .CRS_PIN(crs),
    .COL_PIN(col), .EG_VALID(eg_valid), .EG_DATA(eg_data),
    .EG_READY(eg_ready), .IG_VALID(ig_valid), .IG_DATA(ig_data),
    .IG_EOF(ig_eof), .IG_DROP(ig_drop));

  mii3_far_end u_mii3_far_end (
    .tx_clk(tx_clk), .rx_clk(rx_clk), .dv_in(rx_dv_line),
    .d_in(rxd), .en_out(tx_en), .d_out(txd));

  // ---------------------------------------------------------------
  // clocks and monitors
  // ---------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  // sampled away from the launching edge
  always @(negedge link_clk)
  begin
    if (ig_valid === 1'b1) ig_q.push_back(ig_data);
    if (ig_eof === 1'b1) n_eof++;
    if (ig_eof === 1'b1 && ig_drop === 1'b1) n_drop++;
    if (crs === 1'b1) crs_seen = 1'b1;
    if (col === 1'b1) col_seen = 1'b1;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d of %0d checks", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp_q(input logic [3:0] got[$], input logic [3:0] exp[$]);
    check(8'(got.size()), 8'(exp.size()));
    foreach (exp[i])
      if (i < got.size()) check({4'h0, got[i]}, {4'h0, exp[i]});
  endtask

  task automatic link_wait(input int n);
    repeat (n) @(negedge link_clk);
  endtask

  task automatic eg_send(input logic [3:0] nib[$]);
    int w;
    foreach (nib[i])
    begin
      @(negedge link_clk);
      eg_valid = 1'b1;
      eg_data  = nib[i];
      w = 0;
      // ready is settled before the edge that takes the nibble
      while (eg_ready !== 1'b1 && w < 40)
      begin
        w++;
        @(negedge link_clk);
      end
      if (w >= 40) n_mismatch++;
      @(posedge link_clk);
    end
    @(negedge link_clk);
    eg_valid = 1'b0;
  endtask

  task automatic do_reset(input logic s);
    resetn = 1'b0;
    strap  = s;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    check({7'h0, mode_valid}, 8'h00);
    @(negedge mclk);
    check({7'h0, mode_valid}, 8'h01);
    check({7'h0, mode_phy}, {7'h0, s});
    check({7'h0, rx_dv_oe_n}, 8'h00);
    link_wait(30);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_latch;
    strap = ~strap;
    repeat (10) @(negedge mclk);
    check({7'h0, mode_phy}, {7'h0, ~strap});
    check({7'h0, mode_valid}, 8'h01);
  endtask

  task automatic t_egress;
    u_mii3_far_end.got_q.delete();
    crs_seen = 1'b0;
    eg_send(pat);
    link_wait(10);
    cmp_q(u_mii3_far_end.got_q, pat);
    check({7'h0, crs_seen}, 8'h01);
  endtask

  task automatic t_ingress(input logic err);
    ig_q.delete();
    n_eof  = 0;
    n_drop = 0;
    u_mii3_far_end.send(pat);
    link_wait(10);
    cmp_q(ig_q, pat);
    check(8'(n_eof), 8'h01);
    check(8'(n_drop), {7'h0, err});
  endtask

  task automatic t_collide;
    for (int fd = 1; fd >= 0; fd--)
    begin
      full_duplex = fd[0];
      link_wait(10);
      col_seen = 1'b0;
      fork
        eg_send(pat);
        u_mii3_far_end.send(pat);
      join
      link_wait(10);
      check({7'h0, col_seen}, {7'h0, ~fd[0]});
    end
    full_duplex = 1'b1;
  endtask

  task automatic t_bypass;
    int w;
    @(negedge mclk);
    bp_pin = 1'b1;
    w = 0;
    while (queue_flush !== 1'b1 && w < 8)
    begin
      @(negedge mclk);
      w++;
    end
    check(8'(w), 8'h03);
    @(negedge mclk);
    check({7'h0, queue_flush}, 8'h00);
    check({7'h0, bypass_active}, 8'h01);
    link_wait(10);
    check({7'h0, eg_ready}, 8'h01);
    u_mii3_far_end.got_q.delete();
    eg_send(pat);
    link_wait(10);
    check(8'(u_mii3_far_end.got_q.size()), 8'h00);
    bp_pin = 1'b0;
    repeat (10) @(negedge mclk);
    check({7'h0, bypass_active}, 8'h00);
  endtask

  task automatic t_slow;
    realtime t0;
    speed_100 = 1'b0;
    link_wait(30);
    @(posedge tx_clk);
    t0 = $realtime;
    @(posedge tx_clk);
    check(8'(int'(($realtime - t0) / 30.0)), 8'h0a);
    @(posedge rx_clk);
    t0 = $realtime;
    @(posedge rx_clk);
    check(8'(int'(($realtime - t0) / 30.0)), 8'h0a);
    speed_100 = 1'b1;
    link_wait(30);
  endtask

  task automatic t_mac;
    do_reset(1'b0);
    bp_pin = 1'b1;
    repeat (10) @(negedge mclk);
    check({7'h0, bypass_active}, 8'h00);
    t_ingress(1'b1);
    bp_pin = 1'b0;
    t_ingress(1'b0);
    t_egress();
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    resetn = 1'b0; strap = 1'b1; bp_pin = 1'b0;
    speed_100 = 1'b1; full_duplex = 1'b1;
    eg_valid = 1'b0; eg_data = 4'h0;
    n_mismatch = 0; checks = 0; n_eof = 0; n_drop = 0;
    crs_seen = 1'b0; col_seen = 1'b0;
    do_reset(1'b1);
    t_latch();
    t_egress();
    t_ingress(1'b0);
    t_collide();
    t_bypass();
    t_slow();
    t_mac();
    stop_test();
  end

  initial
  begin
    #400000;
    n_mismatch++;
    stop_test();
  end
endmodule // tb_top
